/* core/cial_pkg.sv */
package cial_pkg;
    // register indices on the plain register port
    localparam logic [3:0]  OFS_LEVEL_FLAG    = 4'h0;
    localparam logic [3:0]  OFS_LEVEL_MASK    = 4'h1;
    localparam logic [3:0]  OFS_VECTOR_OFFSET = 4'h2;
    localparam logic [3:0]  OFS_SYSTEM_STATUS = 4'h3;
    // system status fields
    localparam int          POS_VEC_PENDING   = 0;
    localparam int          POS_GLOBAL_MASK   = 1;
    localparam int          POS_DIV_MODE      = 2;
    localparam int          POS_STACK_FULL    = 3;
    localparam int          POS_DEPTH_LO      = 4;
    // reset values
    localparam logic        RST_GLOBAL_MASK   = 1'b1;
    localparam logic        RST_DIV_MODE      = 1'b0;
    localparam logic [15:0] RST_WORD          = 16'h0000;
    // vector table
    localparam logic [15:0] NMI_VECTOR        = 16'h0024;
    localparam int          LEVEL_VECTOR_STEP = 2;
    // timing counts in core clock cycles
    localparam int          RESP_CYCLES       = 4;
    localparam int          DIV2_CYCLES       = 2;
    localparam int          DIV4_CYCLES       = 4;

    // acknowledge sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESP = 2'b01,
        ST_VECT = 2'b10
    } cial_state_t;

    // register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wrData;
        logic        wrStrobe;
        logic        rdStrobe;
    } cial_bus_t;

    // instruction pipeline status
    typedef struct packed {
        logic instrDone;      // one instruction completes this cycle
        logic isUnmask;       // it cleared the global mask
        logic isMaskSet;      // it set the global mask
        logic isRet;          // it was a return
        logic isCall;         // it entered a subroutine
        logic repeatActive;   // single-instruction repeat running
        logic multicycleBusy; // uninterruptible multicycle operation
        logic waitState;      // ready low or wait-state generator
        logic debugActive;    // breakpoint or single-step in use
    } cial_pipe_t;
endpackage

/* core/cial_core.sv */
// Our own choices: the register addresses and the address-and-strobe port.
module cial_core
    import cial_pkg::*;
#(
    parameter int LEVELS      = 6,
    parameter int STACK_DEPTH = 8
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              nrst,
    // register port
    input  wire cial_bus_t         bus,
    output logic [15:0]            rdData,
    // instruction pipeline
    input  wire cial_pipe_t        pipe,
    input  wire logic [15:0]       retAddr,
    output logic                   intAck,
    output logic                   ackIsNmi,
    output logic [2:0]             ackLevel,
    output logic                   vectorFetch,
    output logic [15:0]            vectorAddr,
    output logic [15:0]            popAddr,
    output logic                   stackFull,
    // interrupt sources
    input  wire logic [LEVELS-1:0] periphReq,
    input  wire logic [15:0]       periphVector,
    input  wire logic [LEVELS-1:0] evReq,
    input  wire logic [LEVELS-1:0] extPin,
    input  wire logic              nmiPin,
    // peripheral clock out
    output logic                   periphClk
);

    localparam int DW = $clog2(STACK_DEPTH + 1);

    // refuse shapes the logic cannot serve
    if (LEVELS < 1 || LEVELS > 7 || STACK_DEPTH < 2) begin : g_check
        $error("cial_core: unsupported LEVELS or STACK_DEPTH");
    end

    // lowest set bit wins: level 1 is highest priority
    function automatic logic [2:0] pickLevel(input logic [LEVELS-1:0] v);
        pickLevel = 3'h0;
        for (int i = LEVELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                pickLevel = 3'(i);
            end
        end
    endfunction

    logic [1:0]             rstPipe;       // reset release synchroniser
    logic                   rstN;          // synchronised reset
    logic [1:0]             divCnt;        // peripheral clock divider
    logic                   periphTick;    // one cycle per peripheral clock
    logic                   divMode;       // 0 divide-by-two, 1 divide-by-four
    logic [LEVELS-1:0]      periphSamp;    // last sampled peripheral requests
    logic [LEVELS-1:0]      extSync1;      // external pin first stage
    logic [LEVELS-1:0]      extSync2;      // external pin second stage
    logic [LEVELS-1:0]      extPrev;       // edge memory for pins
    logic                   nmiSync1;      // nmi pin first stage
    logic                   nmiSync2;      // nmi pin second stage
    logic                   nmiPrev;       // edge memory for nmi
    logic [LEVELS-1:0]      evDly;         // event manager one-cycle delay
    logic [LEVELS-1:0]      evPrev;        // edge memory for events
    logic [LEVELS-1:0]      levelSet;      // new requests this cycle
    logic [LEVELS-1:0]      levelFlag;     // level flag register
    logic [LEVELS-1:0]      levelMask;     // level mask register
    logic                   nmiPend;       // non-maskable request pending
    logic                   nmiSet;        // new non-maskable request
    logic                   globalMask;    // global maskable interrupt mask
    logic [15:0]            vectorOffset;  // vector offset register
    logic                   vecPending;    // vector offset not yet read
    logic                   fence;         // one-instruction interrupt fence
    logic [LEVELS-1:0]      eligible;      // flagged, unmasked levels
    logic                   blocked;       // no interrupt may be taken
    logic                   takeNmi;       // recognise non-maskable now
    logic                   takeMask;      // recognise maskable now
    logic                   take;          // any recognition now
    logic [2:0]             takeLevel;     // level chosen now
    cial_state_t            state;         // acknowledge sequencer
    cial_state_t            next_state;    // its next value
    logic [1:0]             respCnt;       // response cycle counter
    logic [15:0]            stack [STACK_DEPTH]; // return stack, top at 0
    logic [DW-1:0]          depth;         // entries in use
    logic                   push;          // push a return address
    logic                   pop;           // pop a return address
    logic [DW-1:0]          usable;        // usable capacity, one less while debugging
    logic                   rdStatus;      // status read in flight

    // reset is asserted at once and released through two flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    // core clock divided to the peripheral clock
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            divCnt    <= 2'b00;
            periphClk <= 1'b0;
        end else begin
            divCnt    <= divCnt + 2'b01;
            periphClk <= divMode ? divCnt[1] : divCnt[0];
        end
    end
    // tick on the last core cycle of each peripheral clock
    assign periphTick = divMode ? (divCnt == 2'(DIV4_CYCLES - 1)) : (divCnt[0] == 1'(DIV2_CYCLES - 1));

    // peripheral interface samples once per peripheral clock
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            periphSamp <= '0;
        end else if (periphTick) begin
            periphSamp <= periphReq;
        end
    end

    // external pins pass two peripheral clock stages
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            extSync1 <= '0;
            extSync2 <= '0;
            extPrev  <= '0;
            nmiSync1 <= 1'b0;
            nmiSync2 <= 1'b0;
            nmiPrev  <= 1'b0;
        end else if (periphTick) begin
            extSync1 <= extPin;
            extSync2 <= extSync1;
            extPrev  <= extSync2;
            nmiSync1 <= nmiPin;
            nmiSync2 <= nmiSync1;
            nmiPrev  <= nmiSync2;
        end
    end

    // event manager bypasses arbitration, one core cycle late
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            evDly  <= '0;
            evPrev <= '0;
        end else begin
            evDly  <= evReq;
            evPrev <= evDly;
        end
    end

    // rising requests from all three paths
    assign levelSet = (periphTick ? (periphReq & ~periphSamp) | (extSync2 & ~extPrev) : '0)
                    | (evDly & ~evPrev);
    assign nmiSet   = periphTick & nmiSync2 & ~nmiPrev;

    // recognition: priority and blocking windows
    assign eligible  = levelFlag & levelMask;
    assign blocked   = (state != ST_IDLE) | fence | pipe.repeatActive | pipe.multicycleBusy;
    assign takeNmi   = !blocked && nmiPend;
    assign takeMask  = !blocked && !nmiPend && !globalMask && (eligible != '0);
    assign take      = takeNmi | takeMask;
    assign takeLevel = pickLevel(eligible);

    // level flags: new requests win over clears
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            levelFlag <= '0;
        end else begin
            levelFlag <= (levelFlag
                          & ~((bus.wrStrobe && bus.addr == OFS_LEVEL_FLAG) ? bus.wrData[LEVELS-1:0] : '0)
                          & ~(takeMask ? (LEVELS'(1) << takeLevel) : '0))
                         | levelSet;
        end
    end

    // level mask, written by software
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            levelMask <= '0;
        end else if (bus.wrStrobe && bus.addr == OFS_LEVEL_MASK) begin
            levelMask <= bus.wrData[LEVELS-1:0];
        end
    end

    // non-maskable pending flag
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            nmiPend <= 1'b0;
        end else begin
            nmiPend <= nmiSet | (nmiPend & ~takeNmi);
        end
    end

    // global mask: set by any acknowledge, else by instructions
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            globalMask <= RST_GLOBAL_MASK;
        end else if (take) begin
            globalMask <= 1'b1;
        end else if (pipe.instrDone && pipe.isMaskSet) begin
            globalMask <= 1'b1;
        end else if (pipe.instrDone && pipe.isUnmask) begin
            globalMask <= 1'b0;
        end
    end

    // fence after unmask or return lasts one more instruction
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            fence <= 1'b0;
        end else if (pipe.instrDone) begin
            fence <= pipe.isUnmask | pipe.isRet;
        end
    end

    // vector offset and its pending-read bit
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            vectorOffset <= RST_WORD;
            vecPending   <= 1'b0;
        end else if (takeMask) begin
            vectorOffset <= periphVector;
            vecPending   <= 1'b1;
        end else if (bus.rdStrobe && bus.addr == OFS_VECTOR_OFFSET) begin
            vecPending   <= 1'b0;
        end
    end

    // software-set peripheral clock mode
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            divMode <= RST_DIV_MODE;
        end else if (bus.wrStrobe && bus.addr == OFS_SYSTEM_STATUS) begin
            divMode <= bus.wrData[POS_DIV_MODE];
        end
    end

    // acknowledge sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_RESP;
                end
            end
            ST_RESP: begin
                if (respCnt == 2'(RESP_CYCLES - 2)) begin
                    next_state = ST_VECT;
                end
            end
            ST_VECT: begin
                if (!pipe.waitState) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // sequencer, acknowledge and vector address
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            state      <= ST_IDLE;
            respCnt    <= 2'b00;
            intAck     <= 1'b0;
            ackIsNmi   <= 1'b0;
            ackLevel   <= 3'h0;
            vectorAddr <= RST_WORD;
        end else begin
            state   <= next_state;
            respCnt <= (state == ST_RESP) ? respCnt + 2'b01 : 2'b00;
            intAck  <= take;
            if (take) begin
                ackIsNmi   <= takeNmi;
                ackLevel   <= takeNmi ? 3'h0 : takeLevel + 3'h1;
                // nmi vectors to 24h, level n to 2n
                vectorAddr <= takeNmi ? NMI_VECTOR
                                      : 16'((32'(takeLevel) + 1) * LEVEL_VECTOR_STEP);
            end
        end
    end
    assign vectorFetch = (state == ST_VECT);

    // return stack control
    assign push      = take | (pipe.instrDone & pipe.isCall);
    assign pop       = pipe.instrDone & pipe.isRet;
    assign usable    = pipe.debugActive ? DW'(STACK_DEPTH - 1) : DW'(STACK_DEPTH);
    assign stackFull = (depth >= usable);

    // shift stack: pop then push in one cycle replaces the top
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            depth   <= '0;
            popAddr <= RST_WORD;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= RST_WORD;
            end
        end else begin
            if (pop) begin
                popAddr <= stack[0];
            end
            if (push && pop) begin
                stack[0] <= retAddr;
            end else if (push) begin
                stack[0] <= retAddr;
                for (int i = 1; i < STACK_DEPTH; i++) begin
                    stack[i] <= stack[i-1];
                end
                if (depth != DW'(STACK_DEPTH)) begin
                    depth <= depth + DW'(1);
                end
            end else if (pop) begin
                for (int i = 0; i < STACK_DEPTH - 1; i++) begin
                    stack[i] <= stack[i+1];
                end
                if (depth != '0) begin
                    depth <= depth - DW'(1);
                end
            end
        end
    end

    // register reads answer one cycle later
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rdData   <= RST_WORD;
            rdStatus <= 1'b0;
        end else begin
            rdData   <= RST_WORD;
            rdStatus <= bus.rdStrobe && bus.addr == OFS_SYSTEM_STATUS;
            if (bus.rdStrobe) begin
                unique case (bus.addr)
                    OFS_LEVEL_FLAG:    rdData <= 16'(levelFlag);
                    OFS_LEVEL_MASK:    rdData <= 16'(levelMask);
                    OFS_VECTOR_OFFSET: rdData <= vectorOffset;
                    OFS_SYSTEM_STATUS: begin
                        rdData[POS_VEC_PENDING] <= vecPending;
                        rdData[POS_GLOBAL_MASK] <= globalMask;
                        rdData[POS_DIV_MODE]    <= divMode;
                        rdData[POS_STACK_FULL]  <= stackFull;
                        rdData[POS_DEPTH_LO +: DW] <= depth;
                    end
                    default:           rdData <= RST_WORD;
                endcase
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    a_nmi_vector: assert property (takeNmi |=> vectorAddr == NMI_VECTOR ##3 vectorFetch)
        else $error("nmi vector address wrong");
    a_nmi_keeps_offset: assert property (takeNmi && !bus.rdStrobe
                                         |=> $stable(vectorOffset) && $stable(vecPending))
        else $error("nmi disturbed vector offset");
    a_pending_status: assert property (rdStatus |-> rdData[POS_VEC_PENDING] == $past(vecPending))
        else $error("status bit 0 does not show pending read");
    a_ack_latency: assert property (take |=> (state == ST_RESP)[*3] ##1 vectorFetch)
        else $error("response time is not four cycles");
    a_ack_masks: assert property (takeMask |=> globalMask && intAck && vecPending)
        else $error("acknowledge did not set global mask");
    a_fence_blocks: assert property (fence |-> !take)
        else $error("interrupt taken inside fence");
    a_repeat_lock: assert property (pipe.repeatActive || pipe.multicycleBusy |-> !take)
        else $error("interrupt taken during repeat or multicycle");
    a_full_push: assert property (push && !pop && depth == DW'(STACK_DEPTH)
                                  |=> depth == DW'(STACK_DEPTH) && stack[0] == $past(retAddr))
        else $error("push on full stack lost");
    a_event_delay: assert property ((evDly[0] && !evPrev[0]) |=> levelFlag[0])
        else $error("event manager request not flagged");
    a_wait_hold: assert property (vectorFetch && pipe.waitState |=> vectorFetch)
        else $error("vector fetch ended during wait state");

    c_nmi_take:   cover property (takeNmi ##4 vectorFetch);
    c_mask_take:  cover property (takeMask ##1 intAck);
    c_full_push:  cover property (push && depth == DW'(STACK_DEPTH));
    c_ret_and_in: cover property (push && pop);

endmodule // cial_core

/* dv/cial_src_model.sv */
module cial_src_model
    import cial_pkg::*;
#(
    parameter int LEVELS = 6
) (
    // clock
    input  wire logic              clock,
    // command from the bench
    input  wire logic              kick,
    input  wire logic [1:0]        kind,
    input  wire logic [2:0]        lvl,
    input  wire logic [15:0]       vec,
    // request lines towards the core
    output logic [LEVELS-1:0]      periphReq,
    output logic [15:0]            periphVector,
    output logic [LEVELS-1:0]      evReq,
    output logic [LEVELS-1:0]      extPin,
    output logic                   nmiPin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0]        hold   = 4'h0;     // cycles the request stays up
    logic [1:0]        src    = 2'h0;     // 0 periph, 1 event, 2 pin, 3 nmi
    logic [LEVELS-1:0] bitSel = '0;       // one-hot level of the request
    logic [15:0]       vecReg = 16'h0000; // offset offered with the request
    logic              on;                // request active

    // latch a command and hold it long enough for a slow peripheral tick
    always @(posedge clock) begin
        if (kick) begin
            hold   <= 4'h8;
            src    <= kind;
            bitSel <= LEVELS'(1) << (lvl - 3'h1);
            vecReg <= vec;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end else begin
            vecReg <= ~vecReg; // released offset bus keeps changing
        end
    end

    // route the held request to the chosen source
    assign on           = hold != 4'h0;
    assign periphVector = vecReg;
    assign periphReq    = (on && src == 2'h0) ? bitSel : '0;
    assign evReq        = (on && src == 2'h1) ? bitSel : '0;
    assign extPin       = (on && src == 2'h2) ? bitSel : '0;
    assign nmiPin       = on && src == 2'h3;
endmodule // cial_src_model

/* dv/tb.sv */
module tb
    import cial_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // design and source model signals
    logic             clock, nrst, intAck, ackIsNmi, vectorFetch, stackFull, periphClk, nmiPin, kick;
    cial_bus_t        bus;
    cial_pipe_t       pipe;
    logic [15:0]      rdData, retAddr, vectorAddr, popAddr, periphVector, vec;
    logic [15:0]      acks = 16'h0000; // acknowledges seen so far
    logic [2:0]       ackLevel, lvl;
    logic [5:0]       periphReq, evReq, extPin;
    logic [1:0]       kind;
    int               numErrors = 0;
    int               samplesChecked = 0;

    cial_core cial_core_i (.clock, .nrst, .bus, .rdData, .pipe, .retAddr, .intAck, .ackIsNmi,
        .ackLevel, .vectorFetch, .vectorAddr, .popAddr, .stackFull, .periphReq, .periphVector,
        .evReq, .extPin, .nmiPin, .periphClk);
    cial_src_model cial_src_model_i (.clock, .kick, .kind, .lvl, .vec, .periphReq, .periphVector,
        .evReq, .extPin, .nmiPin);

    // core clock, 5 ns period
    always #2.5 clock = ~clock;
    // count acknowledges for the quiet windows
    always @(posedge clock) if (intAck === 1'b1) acks <= acks + 16'h0001;

    task automatic conclude;
        if (numErrors == 0 && samplesChecked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // register port: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
        @(posedge clock);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '0;
        #1 chk($sformatf("reg%0h", a), rdData & m, e);
    endtask

    // one completed instruction with its qualifiers
    task automatic step(input logic u, input logic r, input logic c, input logic [15:0] a);
        @(posedge clock);
        {pipe.instrDone, pipe.isUnmask, pipe.isRet, pipe.isCall, retAddr} <= {1'b1, u, r, c, a};
        @(posedge clock);
        {pipe.instrDone, pipe.isUnmask, pipe.isRet, pipe.isCall} <= 4'h0;
        #1;
    endtask

    task automatic fire(input logic [1:0] k, input logic [2:0] l, input logic [15:0] v);
        @(posedge clock);
        {kick, kind, lvl, vec} <= {1'b1, k, l, v};
        @(posedge clock);
        kick <= 1'b0;
    endtask

    // bounded wait for an acknowledge; running out ends the run
    task automatic waitAck(input int lim);
        int n;
        n = 0;
        while (intAck !== 1'b1) begin
            if (n == lim) begin
                chk("intAck", 16'h0000, 16'h0001);
                conclude();
            end
            @(posedge clock);
            #1 n++;
        end
    endtask

    task automatic quiet(input int n);
        logic [15:0] a;
        a = acks;
        repeat (n) @(posedge clock);
        #1 chk("ackCount", acks, a);
    endtask

    // after intAck: two idle cycles, then the vector fetch, stretched by wait states
    task automatic vfCheck(input logic ws);
        for (int i = 0; i < 7; i++) begin
            @(posedge clock);
            if (i == 0) pipe.waitState <= ws;
            if (i == 5) pipe.waitState <= 1'b0;
            #1 chk("vectorFetch", 16'(vectorFetch), 16'(i >= 2 && i < (ws ? 6 : 3)));
            chk("intAck", 16'(intAck), 16'h0000);
        end
    endtask

    task automatic t_regs;
        rdc(4'h3, 16'h0002);
        rdc(4'h0, 16'h0000);
        rdc(4'h5, 16'h0000);
        wr(4'h2, 16'hFFFF);
        rdc(4'h2, 16'h0000);
        wr(4'h1, 16'h003F);
        rdc(4'h1, 16'h003F);
    endtask

    task automatic t_stack;
        @(posedge clock) pipe.debugActive <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            step(1'b0, 1'b0, 1'b1, 16'h1000 + 16'(i));
            chk("stackFull", 16'(stackFull), 16'(i == 6));
        end
        for (int i = 0; i < 7; i++) begin
            step(1'b0, 1'b1, 1'b0, 16'h0000);
            chk("popAddr", popAddr, 16'h1006 - 16'(i));
        end
        @(posedge clock) pipe.debugActive <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            step(1'b0, 1'b0, 1'b1, 16'h1000 + 16'(i));
            chk("stackFull", 16'(stackFull), 16'(i >= 7));
        end
        for (int i = 0; i < 8; i++) begin
            step(1'b0, 1'b1, 1'b0, 16'h0000);
            chk("popAddr", popAddr, 16'h1008 - 16'(i));
        end
    endtask

    // pending flag held off by unmask, return and repeat fences in turn
    task automatic t_fence;
        step(1'b0, 1'b0, 1'b1, 16'h2000);
        fire(2'h1, 3'h3, 16'h0000);
        quiet(6);
        rdc(4'h0, 16'h0004);
        step(1'b1, 1'b0, 1'b0, 16'h2001);
        quiet(6);
        step(1'b0, 1'b1, 1'b0, 16'h2002);
        chk("popAddr", popAddr, 16'h2000);
        quiet(6);
        @(posedge clock) pipe.repeatActive <= 1'b1;
        step(1'b0, 1'b0, 1'b0, 16'h3333);
        quiet(6);
        // higher level arrives while a multicycle operation holds off level 3
        @(posedge clock) {pipe.repeatActive, pipe.multicycleBusy} <= 2'b01;
        fire(2'h1, 3'h2, 16'h0000);
        quiet(6);
        @(posedge clock) pipe.multicycleBusy <= 1'b0;
        waitAck(50);
        chk("ackLevel", 16'(ackLevel), 16'h0002);
        chk("vectorAddr", vectorAddr, 16'h0004);
        vfCheck(1'b0);
        rdc(4'h0, 16'h0004);
        wr(4'h0, 16'h0004);
        rdc(4'h0, 16'h0000);
        rdc(4'h3, 16'h0012, 16'hFFFE);
        step(1'b0, 1'b1, 1'b0, 16'h0000);
        chk("popAddr", popAddr, 16'h3333);
    endtask

    // peripheral, event and pin requests, each with its latency bound
    task automatic t_src;
        for (int k = 0; k < 3; k++) begin
            step(1'b1, 1'b0, 1'b0, 16'h0000);
            step(1'b0, 1'b0, 1'b0, 16'h4000);
            fire(2'(k), 3'(2 * k + 1), 16'h00A0 + 16'(k));
            waitAck(6 + 2 * k);
            chk("ackLevel", 16'(ackLevel), 16'(2 * k + 1));
            chk("vectorAddr", vectorAddr, 16'(4 * k + 2));
            vfCheck(k == 2);
            if (k == 0) rdc(4'h3, 16'h0013);
            rdc(4'h2, 16'h00A0 + 16'(k));
            rdc(4'h3, 16'h0012);
            step(1'b0, 1'b1, 1'b0, 16'h0000);
        end
    endtask

    // non-maskable request while a vector read is still pending
    task automatic t_nmi;
        step(1'b1, 1'b0, 1'b0, 16'h0000);
        step(1'b0, 1'b0, 1'b0, 16'h5000);
        fire(2'h0, 3'h2, 16'h005A);
        waitAck(50);
        vfCheck(1'b0);
        fire(2'h3, 3'h0, 16'h0000);
        waitAck(50);
        chk("ackIsNmi", 16'(ackIsNmi), 16'h0001);
        chk("vectorAddr", vectorAddr, 16'h0024);
        vfCheck(1'b0);
        rdc(4'h3, 16'h0023);
        rdc(4'h2, 16'h005A);
        rdc(4'h3, 16'h0022);
        step(1'b0, 1'b1, 1'b0, 16'h0000);
        step(1'b0, 1'b1, 1'b0, 16'h0000);
    endtask

    // count peripheral clock changes over sixteen core cycles
    task automatic t_clk(input logic [15:0] e);
        logic        p;
        logic [15:0] n;
        n = 16'h0000;
        @(posedge clock);
        #1 p = periphClk;
        repeat (16) begin
            @(posedge clock);
            #1 n = n + 16'(periphClk != p);
            p = periphClk;
        end
        chk("periphClk", n, e);
    endtask

    // reset, then the scenarios in order
    initial begin
        clock = 1'b0;
        bus = '0;
        pipe = '0;
        {nrst, kick, kind, lvl, vec, retAddr} = '0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_stack();
        t_fence();
        t_src();
        t_nmi();
        t_clk(16'h0010);
        wr(4'h3, 16'h0004);
        rdc(4'h3, 16'h0006);
        t_clk(16'h0008);
        conclude();
    end
endmodule // tb
